// ==== src/sar_seq_defines.svh ====
// Timing and layout constants of the conversion sequencer.
// Assumes inclusion by bare name from the package and the design.
`ifndef SAR_SEQ_DEFINES_SVH
`define SAR_SEQ_DEFINES_SVH
`define RESULT_BITS       8
`define CLOCKS_PER_BIT    8
`define SYNC_ALIGN_MAX    8
`define ALIGN_CLOCKS      4
`define CONV_MIN          62
`define CONV_MAX          73
`define CONV_CNT_W        7
`define NEG_SAMPLE_PHASE  4
`define PHASE_W           3
`define RESULT_ZERO       8'h00
`endif

// ==== src/sar_seq_pkg.sv ====
// Types shared by the conversion sequencer.
// Assumes the defines header is on the include path.
`include "sar_seq_defines.svh"
package sar_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HOLD  = 2'b01,
    ST_ALIGN = 2'b10,
    ST_RUN   = 2'b11
  } seq_state_t;
endpackage : sar_seq_pkg

// ==== src/sar_conversion_sequencer.sv ====
// Digital sequencer of an 8-bit successive-approximation converter.
// Assumes strobes synchronous to clk and an external comparator result.
// Overview of operation
// - Conversion completes 62 to 73 clock periods after the start request.
// - Done looped to start with select low gives free-running conversions.
// - Most significant bit first, eight comparisons over 64 clocks.
// - Result is straight binary, all ones means full scale.
// - Start falling edge resets register, stages, and raises done_n.
// - Select and start both low hold the sequencer in reset.
// - Conversion begins 1 to 8 clocks after select or start rises.
// - After the conversion clocks elapse, done_n falls.
// - Read with select low returns done_n high.
// - New start during conversion aborts and restarts.
// - Start condition sets start flop, clears stages, and clears done flop unless the end stage sets it in that cycle.
// - Start flop clears only once the set condition is removed.
// - One leaving the last stage copies result into output latches.
// - Next end-stage clock sets done flop; pin shows its inverse.
// - Select and read low enable all eight data outputs.
// - Read rising returns data outputs to high impedance.
// - Positive and negative inputs sampled 4 clocks apart.
// - Negative input at or above positive gives all zeros.
`timescale 1ns/100ps
`include "sar_seq_defines.svh"
module sar_conversion_sequencer #(
  parameter int RESULT_BITS = `RESULT_BITS,
  parameter int BIT_CLOCKS  = `CLOCKS_PER_BIT
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   chip_select_n,
  input  wire logic                   start_n,
  input  wire logic                   read_n,
  input  wire logic                   compare_high,
  input  wire logic                   neg_at_or_above,
  output logic                        sample_pos,
  output logic                        sample_neg,
  output logic [RESULT_BITS-1:0]      trial_word,
  output logic                        done_flag_n,
  output logic [RESULT_BITS-1:0]      data_out,
  output logic [RESULT_BITS-1:0]      data_oe,
  output sar_seq_pkg::seq_state_t     seq_state
);
  import sar_seq_pkg::*;

  // Only the documented word and bit timing is served; refuse anything else
  if (RESULT_BITS != `RESULT_BITS || BIT_CLOCKS != `CLOCKS_PER_BIT) begin : g_bad_params
    $error("sequencer supports only 8 bits of 8 clocks");
  end

  // Registers
  seq_state_t                 state_reg, state_next;
  logic                       start_ff_reg;
  logic [`PHASE_W-1:0]        phase_reg;
  logic [RESULT_BITS-1:0]     start_capture_stage;
  logic                       end_of_sequence_stage;
  logic [RESULT_BITS-1:0]     approximation_register;
  logic [RESULT_BITS-1:0]     latch_reg;
  logic                       done_ff_reg;
  logic                       start_n_d;
  logic [`PHASE_W-1:0]        align_reg;

  // Decoding of strobes
  wire set_cond   = ~chip_select_n & ~start_n;
  wire start_fall = ~chip_select_n & ~start_n & start_n_d;
  wire read_act   = ~chip_select_n & ~read_n;
  wire phase_last = (phase_reg == `PHASE_W'(BIT_CLOCKS - 1));
  wire shift_out  = start_capture_stage[0] & phase_last & (state_reg == ST_RUN);
  wire latch_transfer_gate = shift_out;
  wire start_clear_gate    = (state_reg == ST_HOLD) & ~set_cond;
  // Short alignment keeps the whole conversion inside its clock budget
  wire align_done = (align_reg == `PHASE_W'(`ALIGN_CLOCKS - 1));
  wire [RESULT_BITS-1:0] kept_word =
    approximation_register & ~(start_capture_stage & {RESULT_BITS{~compare_high}});
  wire [RESULT_BITS-1:0] final_word =
    neg_at_or_above ? `RESULT_ZERO : kept_word;

  // Sequencer state decision
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (set_cond) state_next = ST_HOLD;
      ST_HOLD:  if (start_clear_gate) state_next = ST_ALIGN;
      ST_ALIGN: if (set_cond) state_next = ST_HOLD;
                else if (align_done) state_next = ST_RUN;
      ST_RUN:   if (set_cond) state_next = ST_HOLD;
                else if (shift_out) state_next = ST_IDLE;
    endcase
  end

  // State and start flop
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      start_ff_reg <= 1'b0;
      start_n_d    <= 1'b1;
    end else if (clk_en) begin
      state_reg    <= state_next;
      start_ff_reg <= (state_next == ST_HOLD);
      start_n_d    <= start_n;
    end
  end

  // Phase alignment counter, models the clock-phase wait
  always_ff @(posedge clk) begin
    if (reset || (clk_en && state_reg != ST_ALIGN)) begin
      align_reg <= '0;
    end else if (clk_en) begin
      align_reg <= align_reg + `PHASE_W'(1);
    end
  end

  // Shift stages and approximation register, MSB first
  always_ff @(posedge clk) begin
    if (reset || (clk_en && (set_cond || state_reg == ST_HOLD))) begin
      start_capture_stage    <= '0;
      approximation_register <= '0;
      phase_reg              <= '0;
    end else if (clk_en && state_reg == ST_ALIGN && align_done) begin
      start_capture_stage    <= {1'b1, {(RESULT_BITS-1){1'b0}}};
      approximation_register <= {1'b1, {(RESULT_BITS-1){1'b0}}};
      phase_reg              <= '0;
    end else if (clk_en && state_reg == ST_RUN) begin
      phase_reg <= phase_reg + `PHASE_W'(1);
      if (phase_last) begin
        start_capture_stage    <= start_capture_stage >> 1;
        approximation_register <= kept_word | (start_capture_stage >> 1);
      end
    end
  end

  // End stage, done flop and output latches
  always_ff @(posedge clk) begin
    if (reset) begin
      end_of_sequence_stage <= 1'b0;
      done_ff_reg <= 1'b0;
      latch_reg   <= '0;
    end else if (clk_en) begin
      end_of_sequence_stage <= latch_transfer_gate;
      if (latch_transfer_gate)
        latch_reg <= final_word;
      if (end_of_sequence_stage)
        done_ff_reg <= 1'b1;
      else if (set_cond || read_act)
        done_ff_reg <= 1'b0;
    end
  end

  // Registered pin drivers
  always_ff @(posedge clk) begin
    if (reset) begin
      done_flag_n <= 1'b1;
      data_out    <= '0;
      data_oe     <= '0;
      sample_pos  <= 1'b0;
      sample_neg  <= 1'b0;
      trial_word  <= '0;
      seq_state   <= ST_IDLE;
    end else if (clk_en) begin
      done_flag_n <= ~((done_ff_reg | end_of_sequence_stage) &
                       ~(set_cond | read_act));
      data_out    <= latch_reg;
      data_oe     <= {RESULT_BITS{read_act}};
      sample_pos  <= (state_reg == ST_RUN) && (phase_reg == '0);
      sample_neg  <= (state_reg == ST_RUN) && (phase_reg == `PHASE_W'(`NEG_SAMPLE_PHASE));
      trial_word  <= approximation_register;
      seq_state   <= state_reg;
    end
  end

  // Clocks since the start request was released, saturating; only the
  // length assertion reads it, so synthesis may prune it
  logic [`CONV_CNT_W-1:0]     conv_clocks_reg;
  wire conv_cnt_full = (conv_clocks_reg == {`CONV_CNT_W{1'b1}});
  always_ff @(posedge clk) begin
    if (reset || (clk_en && set_cond)) begin
      conv_clocks_reg <= '0;
    end else if (clk_en && !conv_cnt_full) begin
      conv_clocks_reg <= conv_clocks_reg + `CONV_CNT_W'(1);
    end
  end

  // Assertions. A frozen clock enable stretches every window below,
  // so each property except a_sample_gap qualifies its steps on clk_en.

  // Start request as seen by the sequencer
  sequence s_start;
    ~chip_select_n & ~start_n & clk_en;
  endsequence

  // Start released while the sequencer waits in its held state
  sequence s_release;
    (state_reg == ST_HOLD) & ~set_cond & clk_en;
  endsequence

  // Last bit decided and result handed to the latches
  sequence s_transfer;
    latch_transfer_gate & clk_en;
  endsequence

  // Transfer followed by one more enabled clock for the end stage
  sequence s_transfer_then_end;
    s_transfer ##1 clk_en;
  endsequence

  // A start request raises done_n on the next edge
  a_start_raises_done: assert property (@(posedge clk) disable iff (reset)
    s_start |=> done_flag_n)
    else $error("done_n not high after start");

  // Falling start clears register and stages
  a_fall_resets: assert property (@(posedge clk) disable iff (reset)
    (start_fall && clk_en) |=> (start_capture_stage == '0 && approximation_register == '0 && done_flag_n))
    else $error("falling start did not reset");

  // Held start keeps the sequencer parked
  a_hold_in_reset: assert property (@(posedge clk) disable iff (reset)
    (set_cond && clk_en) |=> (state_reg == ST_HOLD))
    else $error("not held in reset");

  // Start condition sets the start flop and clears the done flop
  a_start_flop_set: assert property (@(posedge clk) disable iff (reset)
    (set_cond && clk_en && !end_of_sequence_stage) |=> (start_ff_reg && !done_ff_reg && start_capture_stage == '0))
    else $error("start flop not set");

  // Removing the set condition lets the start flop clear
  a_release_to_align: assert property (@(posedge clk) disable iff (reset)
    s_release |=> (state_reg == ST_ALIGN))
    else $error("start flop not cleared");

  // Set condition still present: stages stay in reset
  a_held_while_set: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_HOLD && set_cond && clk_en) |=> (state_reg == ST_HOLD && start_capture_stage == '0))
    else $error("left hold with start still set");

  // Conversion never begins on the release edge itself
  a_align_min: assert property (@(posedge clk) disable iff (reset)
    s_release |=> (state_reg != ST_RUN))
    else $error("start too early");

  // Alignment lasts at most eight clocks
  a_align_bound: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_ALIGN && !set_cond && clk_en) [*8] |=> (state_reg != ST_ALIGN))
    else $error("start too late");

  // First trial bit is the most significant
  a_msb_first: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_ALIGN && align_done && !set_cond && clk_en) |=> (start_capture_stage[RESULT_BITS-1]))
    else $error("msb not first");

  // Stages move only on the last clock of a bit
  a_bit_spacing: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_RUN && !phase_last && !set_cond && clk_en) |=> $stable(start_capture_stage))
    else $error("bit step off its clock");

  // Done falls within the documented clock budget of the request
  a_conv_length: assert property (@(posedge clk) disable iff (reset)
    (clk_en && $fell(done_flag_n)) |->
      (conv_clocks_reg >= `CONV_CNT_W'(`CONV_MIN) && conv_clocks_reg <= `CONV_CNT_W'(`CONV_MAX)))
    else $error("conversion length out of range");

  // Transfer copies the decided word into the latches
  a_latch_copy: assert property (@(posedge clk) disable iff (reset)
    s_transfer |=> (latch_reg == $past(final_word)))
    else $error("latch not loaded");

  // End stage sets the done flop
  a_done_ff_set: assert property (@(posedge clk) disable iff (reset)
    (end_of_sequence_stage && clk_en) |=> done_ff_reg)
    else $error("done flop not set");

  // Done pin low once the end stage has clocked
  a_latch_then_done: assert property (@(posedge clk) disable iff (reset)
    s_transfer_then_end |=> !done_flag_n)
    else $error("done_n not low after latch");

  // Read returns done_n high
  a_read_clears_done: assert property (@(posedge clk) disable iff (reset)
    (read_act && clk_en && !end_of_sequence_stage) |=> done_flag_n)
    else $error("read did not clear done");

  // Read drives every data bit
  a_read_drives_bus: assert property (@(posedge clk) disable iff (reset)
    (read_act && clk_en) |=> (data_oe == '1))
    else $error("bus not driven on read");

  // Data pins show the latch contents
  a_latch_on_pins: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> (data_out == $past(latch_reg)))
    else $error("data pins differ from latch");

  // No read, no drive
  a_release_bus: assert property (@(posedge clk) disable iff (reset)
    (!read_act && clk_en) |=> (data_oe == '0))
    else $error("bus not released");

  // Negative sample follows positive by the fixed gap
  a_sample_gap: assert property (@(posedge clk) disable iff (reset)
    (sample_neg && clk_en) |-> $past(sample_pos, 4))
    else $error("sample gap wrong");

  // New start in a run aborts it
  a_abort_restart: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_RUN && set_cond && clk_en) |=> (start_capture_stage == '0))
    else $error("no abort");

  // Negative input on top forces the zero code
  a_zero_code: assert property (@(posedge clk) disable iff (reset)
    (latch_transfer_gate && neg_at_or_above && clk_en) |=> (latch_reg == '0))
    else $error("not zero code");
endmodule : sar_conversion_sequencer

// ==== test/comparator_model.sv ====
// Behavioural comparator standing beside the sequencer.
// Assumes the sequencer presents its trial word and samples the answer later.
`timescale 1ns/100ps
module comparator_model (
  input  wire logic [7:0] trial_word,
  input  wire logic [7:0] level,
  output logic            compare_high
);
  // Ideal comparison, no offset or noise modelled
  assign compare_high = (level >= trial_word);
endmodule : comparator_model

// ==== test/tb_sar_conversion_sequencer.sv ====
// Bench for the conversion sequencer: convert, read, zero code, abort, hold.
// Assumes the comparator model and the design sources compiled before it.
`timescale 1ns/100ps
module tb_sar_conversion_sequencer;
  import sar_seq_pkg::*;
  logic       clk = 1'b0, reset = 1'b1, cs_n = 1'b1, start_n = 1'b1, read_n = 1'b1, neg = 1'b0;
  logic [7:0] level = 8'h00;
  logic       cmp, s_pos, s_neg, done_n;
  logic [7:0] trial, dout, doe;
  seq_state_t state;
  int         mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  comparator_model cmpm (.trial_word(trial), .level(level), .compare_high(cmp));
  sar_conversion_sequencer dut (.clk(clk), .reset(reset), .clk_en(1'b1), .chip_select_n(cs_n),
    .start_n(start_n), .read_n(read_n), .compare_high(cmp), .neg_at_or_above(neg), .sample_pos(s_pos),
    .sample_neg(s_neg), .trial_word(trial), .done_flag_n(done_n), .data_out(dout), .data_oe(doe),
    .seq_state(state));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Sample a little after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse_start(input int w);
    @(posedge clk);
    start_n <= 1'b0;
    repeat (w) @(posedge clk);
    start_n <= 1'b1;
  endtask : pulse_start
  // Bounded wait; a hang ends the run
  task automatic wait_done(output int cyc);
    cyc = 0;
    #1;
    while (done_n !== 1'b0 && cyc < 200) begin
      tick(1);
      cyc++;
    end
    if (cyc >= 200) begin
      mismatches++;
      $display("[ERR] done_flag_n expected 0 seen timeout");
      tally_and_finish();
    end
  endtask : wait_done
  task automatic read_check(input logic [7:0] exp);
    @(posedge clk);
    read_n <= 1'b0;
    tick(2);
    chk("data_oe", 8'hFF, doe);
    chk("data_out", exp, dout);
    chk("done_flag_n after read", 8'h01, {7'h0, done_n});
    @(posedge clk);
    read_n <= 1'b1;
    tick(2);
    chk("data_oe released", 8'h00, doe);
  endtask : read_check
  task automatic t_convert(input logic [7:0] lv, input logic ng, input logic [7:0] exp);
    int cyc;
    level <= lv;
    neg <= ng;
    pulse_start(1);
    wait_done(cyc);
    chk("conversion clocks", 8'h01, {7'h0, cyc >= 62});
    chk("conversion clocks max", 8'h01, {7'h0, cyc <= 73});
    read_check(exp);
    $display("convert %h finished", lv);
  endtask : t_convert
  // Restart mid-run must discard the first conversion
  task automatic t_abort;
    int cyc;
    level <= 8'h3C;
    neg <= 1'b0;
    pulse_start(1);
    tick(30);
    chk("mid-run done_flag_n", 8'h01, {7'h0, done_n});
    pulse_start(1);
    wait_done(cyc);
    chk("restart clocks", 8'h01, {7'h0, cyc >= 62});
    chk("restart clocks max", 8'h01, {7'h0, cyc <= 73});
    read_check(8'h3C);
    $display("abort finished");
  endtask : t_abort
  // Wide start over an unread result: flag rises, sequencer waits
  task automatic t_hold;
    int cyc;
    level <= 8'h81;
    neg <= 1'b0;
    pulse_start(1);
    wait_done(cyc);
    @(posedge clk);
    start_n <= 1'b0;
    tick(40);
    chk("hold done_flag_n", 8'h01, {7'h0, done_n});
    chk("hold state", {6'h0, ST_HOLD}, {6'h0, state});
    @(posedge clk);
    start_n <= 1'b1;
    wait_done(cyc);
    chk("after hold clocks", 8'h01, {7'h0, cyc >= 62});
    chk("after hold clocks max", 8'h01, {7'h0, cyc <= 73});
    read_check(8'h81);
    $display("hold finished");
  endtask : t_hold
  // Done looped back to start with select low: conversions chain by themselves
  task automatic t_freerun;
    int   falls;
    int   k;
    logic prev;
    falls = 0;
    prev = 1'b1;
    level <= 8'h5A;
    neg <= 1'b0;
    pulse_start(1);
    for (k = 0; k < 400 && falls < 3; k++) begin
      @(posedge clk);
      start_n <= done_n;
      if (prev && !done_n) falls++;
      prev = done_n;
    end
    @(posedge clk);
    start_n <= 1'b1;
    chk("free-run conversions", 8'h03, 8'(falls));
    $display("free-run finished");
  endtask : t_freerun
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    cs_n <= 1'b0;
    t_convert(8'hA5, 1'b0, 8'hA5);
    t_convert(8'hFF, 1'b0, 8'hFF);
    t_convert(8'h80, 1'b1, 8'h00);
    t_abort();
    t_hold();
    t_freerun();
    tally_and_finish();
  end
endmodule : tb_sar_conversion_sequencer
